// ==== cpw_pwm_unit.sv ====
// Purpose: PWM mode of a capture/compare/PWM unit with its period timer
// Assumes: 10 MHz system clock stands for the oscillator; plain register port
// Notes:   Duty value is double buffered and, in PWM mode, loaded only at period match
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "cpw_params.svh"

module cpw_pwm_unit
    import cpw_pkg::*;
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    // Register port
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Port direction bit driven by software elsewhere
    input  wire logic       i_port_direction,
    // PWM pin
    output logic            o_pwm_output_pin,
    output logic            o_pwm_output_pin_oe
);

    // ----------------------------------------
    // Request bundle and decode
    // ----------------------------------------
    cpw_req_t req;
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    wire wr_count   = req.wr && (req.addr == `CPW_OFS_TIMER_COUNT);
    wire wr_period  = req.wr && (req.addr == `CPW_OFS_PERIOD_LIMIT);
    wire wr_tctrl   = req.wr && (req.addr == `CPW_OFS_TIMER_CONTROL);
    wire wr_duty    = req.wr && (req.addr == `CPW_OFS_DUTY_UPPER);
    wire wr_shadow  = req.wr && (req.addr == `CPW_OFS_DUTY_SHADOW);
    wire wr_uctrl   = req.wr && (req.addr == `CPW_OFS_UNIT_CONTROL);

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    logic [7:0] period_limit_r;     // Period limit
    logic [7:0] timer_control_r;    // Run, prescale, postscale
    logic [7:0] duty_upper_bits_r;  // Duty eight upper bits
    logic [7:0] duty_shadow_high_r; // Shadow of duty upper bits
    logic [1:0] duty_shadow_low_r;  // Two-bit internal latch
    logic [7:0] unit_control_r;     // Duty low bits and mode
    logic       pin_r;              // PWM output latch
    logic       pin_oe_r;           // Output enable
    logic [7:0] rdata_r;            // Read data register

    // Control fields
    wire        timer_run   = timer_control_r[`CPW_TC_RUN_BIT];
    wire [1:0]  timer_prescale_select = timer_control_r[`CPW_TC_PS_LSB +: 2];
    wire        pwm_mode    = unit_control_r[`CPW_UC_MODE_HI]
                              && unit_control_r[`CPW_UC_MODE_LO];
    wire [1:0]  duty_low    = unit_control_r[`CPW_UC_DUTY_LSB +: 2];
    wire        unit_off    = (unit_control_r == `CPW_RST_BYTE);

    // Register writes; postscale kept but has no effect on the PWM
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            period_limit_r    <= `CPW_RST_PERIOD;
            timer_control_r   <= `CPW_RST_BYTE;
            duty_upper_bits_r <= `CPW_RST_BYTE;
            unit_control_r    <= `CPW_RST_BYTE;
        end
        else
        begin
            if (wr_period)
                period_limit_r <= req.wdata;
            if (wr_tctrl)
                timer_control_r <= req.wdata & `CPW_TC_MASK;
            if (wr_duty)
                duty_upper_bits_r <= req.wdata;
            if (wr_uctrl)
                unit_control_r <= req.wdata & `CPW_UC_MASK;
        end
    end

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    cpw_tbase_t tb;

    cpw_timebase u_timebase
    (
        .i_sys_clk   (i_sys_clk),
        .i_reset_n   (i_reset_n),
        .i_run       (timer_run),
        .i_ps_sel    (timer_prescale_select),
        .i_period    (period_limit_r),
        .i_cnt_wr    (wr_count),
        .i_cnt_wdata (req.wdata),
        .o_tb        (tb)
    );

    // ----------------------------------------
    // Duty compare
    // ----------------------------------------
    // Ten-bit duty written by software
    wire [9:0] duty_written = {duty_upper_bits_r, duty_low};
    wire [9:0] duty_shadow  = {duty_shadow_high_r, duty_shadow_low_r};
    // Count extended by the phase bits, compared at every sub step
    wire [9:0] count_ext    = {tb.count, tb.sub};
    // Compare fires on the sub step that completes, so high time is duty steps.
    // The carry into the count matters on the last phase of each increment,
    // otherwise duties that are multiples of four would never match.
    wire [9:0] count_nxt    = count_ext + 10'h001;
    wire       period_load  = pwm_mode && tb.tick && tb.match;
    wire       duty_hit     = (duty_shadow == count_nxt) && (duty_shadow != 10'h000);

    // Prescaler edge gating; only compare on a real sub step
    logic [3:0] step_pre_r;         // Mirror of prescale phase
    wire [3:0]  step_lim = (timer_prescale_select == CPW_PS_DIV1) ? 4'h0 :
                           (timer_prescale_select == CPW_PS_DIV4) ? 4'h3 : 4'hF;
    wire        step     = timer_run && (step_pre_r == step_lim);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            step_pre_r <= 4'h0;
        else if (timer_run)
            step_pre_r <= (step_pre_r == step_lim) ? 4'h0 : step_pre_r + 4'h1;
    end

    // Shadow load; software cannot write the shadow in PWM mode
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            duty_shadow_high_r <= `CPW_RST_BYTE;
            duty_shadow_low_r  <= 2'h0;
        end
        else if (period_load)
        begin
            duty_shadow_high_r <= duty_upper_bits_r;
            duty_shadow_low_r  <= duty_low;
        end
        else if (wr_shadow && !pwm_mode)
            duty_shadow_high_r <= req.wdata;
    end

    // ----------------------------------------
    // Output latch
    // ----------------------------------------
    // Period start sets unless the duty is zero, compare clears; a duty beyond the period never
    // matches so the pin stays high. Unit off forces the latch low.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            pin_r <= 1'b0;
        else if (unit_off || !pwm_mode)
            pin_r <= 1'b0;
        else if (period_load)
            pin_r <= (duty_written != 10'h000);
        else if (step && duty_hit && pin_r)
            pin_r <= 1'b0;
    end

    // Pin drives only when the port direction selects output
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            pin_oe_r <= 1'b0;
        else
            pin_oe_r <= !i_port_direction;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (req.addr)
            `CPW_OFS_TIMER_COUNT:   rd_mux = tb.count;
            `CPW_OFS_PERIOD_LIMIT:  rd_mux = period_limit_r;
            `CPW_OFS_TIMER_CONTROL: rd_mux = timer_control_r;
            `CPW_OFS_DUTY_UPPER:    rd_mux = duty_upper_bits_r;
            `CPW_OFS_DUTY_SHADOW:   rd_mux = duty_shadow_high_r;
            `CPW_OFS_UNIT_CONTROL:  rd_mux = unit_control_r;
            default:                rd_mux = 8'h00;
        endcase
    end

    // Read data valid one cycle after the strobe, zero otherwise
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            rdata_r <= 8'h00;
        else
            rdata_r <= req.rd ? rd_mux : 8'h00;
    end

    assign o_rdata             = rdata_r;
    assign o_pwm_output_pin    = pin_r;
    assign o_pwm_output_pin_oe = pin_oe_r;

endmodule
`default_nettype wire

// ==== cpw_params.svh ====
// Purpose: Offsets, field positions, reset values and timing counts for the PWM unit
// Assumes: Included by the design files by bare name
// Notes:   Definitions only
`ifndef CPW_PARAMS_SVH
`define CPW_PARAMS_SVH

// ----------------------------------------
// Register offsets (plain port address)
// ----------------------------------------
`define CPW_ADDR_W            3
`define CPW_OFS_TIMER_COUNT   3'h0
`define CPW_OFS_PERIOD_LIMIT  3'h1
`define CPW_OFS_TIMER_CONTROL 3'h2
`define CPW_OFS_DUTY_UPPER    3'h3
`define CPW_OFS_DUTY_SHADOW   3'h4
`define CPW_OFS_UNIT_CONTROL  3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CPW_TC_RUN_BIT        2
`define CPW_TC_PS_LSB         0
`define CPW_TC_POST_LSB       3
`define CPW_UC_DUTY_LSB       4
`define CPW_UC_MODE_HI        3
`define CPW_UC_MODE_LO        2
`define CPW_TC_MASK           8'h7F
`define CPW_UC_MASK           8'h3F

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CPW_RST_BYTE          8'h00
`define CPW_RST_PERIOD        8'hFF
`define CPW_Q_PHASES          4

`endif

// ==== cpw_pkg.sv ====
// Purpose: Types shared by the PWM unit files
// Assumes: Used together with cpw_params.svh
// Notes:   Types only; numbers live in the header
package cpw_pkg;

    // Prescale select encoding
    typedef enum logic [1:0]
    {
        CPW_PS_DIV1  = 2'b00,
        CPW_PS_DIV4  = 2'b01,
        CPW_PS_DIV16 = 2'b10,
        CPW_PS_DIV16B = 2'b11
    } cpw_prescale_t;

    // Register port request
    typedef struct packed
    {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cpw_req_t;

    // Timer snapshot passed to the pulse stage
    typedef struct packed
    {
        logic [7:0] count;
        logic [1:0] sub;
        logic       tick;
        logic       match;
    } cpw_tbase_t;

endpackage

// ==== cpw_timebase.sv ====
// Purpose: Period timer with prescaler and sub-cycle phase counter
// Assumes: Runs on the system clock, one oscillator period per clock
// Notes:   Sub count supplies two extra low bits for the duty compare
`timescale 1ns/100ps
`default_nettype none
`include "cpw_params.svh"

module cpw_timebase
    import cpw_pkg::*;
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    // Control
    input  wire logic       i_run,
    input  wire logic [1:0] i_ps_sel,
    input  wire logic [7:0] i_period,
    input  wire logic       i_cnt_wr,
    input  wire logic [7:0] i_cnt_wdata,
    // Timer state
    output cpw_tbase_t      o_tb
);

    // ----------------------------------------
    // Prescale decode
    // ----------------------------------------
    // Oscillator periods per sub step, minus one
    function automatic logic [3:0] ps_limit(input logic [1:0] sel);
        unique case (sel)
            CPW_PS_DIV1:  ps_limit = 4'h0;
            CPW_PS_DIV4:  ps_limit = 4'h3;
            default:      ps_limit = 4'hF;
        endcase
    endfunction

    logic [3:0] pre_r;      // Prescale divider
    logic [1:0] sub_r;      // Q-phase or prescaler low bits
    logic [7:0] cnt_r;      // Period timer
    wire        pre_end = (pre_r == ps_limit(i_ps_sel));
    wire        inc     = i_run && pre_end && (sub_r == 2'h3);
    wire        match   = (cnt_r == i_period);

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    // Sub count walks four phases per timer increment
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            pre_r <= 4'h0;
            sub_r <= 2'h0;
            cnt_r <= `CPW_RST_BYTE;
        end
        else
        begin
            // Prescaler halts with the timer
            if (!i_run)
                pre_r <= pre_r;
            else if (pre_end)
                pre_r <= 4'h0;
            else
                pre_r <= pre_r + 4'h1;
            if (i_run && pre_end)
                sub_r <= sub_r + 2'h1;
            // Software write wins over counting
            if (i_cnt_wr)
                cnt_r <= i_cnt_wdata;
            else if (inc)
                cnt_r <= match ? 8'h00 : cnt_r + 8'h01;
        end
    end

    // Snapshot for the pulse stage
    assign o_tb = '{count: cnt_r, sub: sub_r, tick: inc, match: match};

endmodule
`default_nettype wire

// ==== cpw_pwm_unit_assertions.sv ====
// Purpose: Port checks for the PWM unit
// Assumes: Sync active-low reset, one clock
// Notes:   Mirrors written bytes to judge the pin
`timescale 1ns/100ps
`default_nettype none
module cpw_assertions
(
    // Clock and reset
    input wire logic       i_sys_clk,
    input wire logic       i_reset_n,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // Pin side
    input wire logic       i_port_direction,
    input wire logic       o_pwm_output_pin,
    input wire logic       o_pwm_output_pin_oe
);
    // ----------
    // Mirror of written bytes
    // ----------
    logic       rst_q_r; // Masks the edge that ends reset
    logic [7:0] du_r;    // Duty upper byte
    logic [5:0] uc_r;    // Unit control
    wire  logic [9:0] duty_w = {du_r, uc_r[5:4]};
    wire  logic       pin    = o_pwm_output_pin;
    wire  logic       pwm_w  = (uc_r[3:2] == 2'h3);

    // Follow software writes
    always_ff @(posedge i_sys_clk)
    begin
        rst_q_r <= i_reset_n;
        if (!i_reset_n)
        begin
            du_r <= 8'h00;
            uc_r <= 6'h00;
        end
        else if (i_wr && i_addr == 3'h3)
            du_r <= i_wdata;
        else if (i_wr && i_addr == 3'h5)
            uc_r <= i_wdata[5:0];
    end

    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    // First edge after release still sees reset history
    default disable iff (!i_reset_n || !rst_q_r);

    a_ctl_bit7_zero: assert property (i_rd && i_addr == 3'h2 |=> !o_rdata[7])
        else $error("timer control bit 7 set");
    a_uc_top_zero: assert property (i_rd && i_addr == 3'h5 |=> o_rdata[7:6] == 2'h0)
        else $error("unit control top bits set");
    a_oe_follows: assert property (o_pwm_output_pin_oe == !$past(i_port_direction))
        else $error("pin enable wrong");
    a_clear_low: assert property (uc_r == 6'h00 && $past(uc_r) == 6'h00 |-> !pin)
        else $error("pin high with control clear");
    a_mode_low: assert property (!pwm_w && !$past(pwm_w) |-> !pin)
        else $error("pin high outside pwm mode");
    a_rise_mode: assert property ($rose(pin) |-> $past(pwm_w))
        else $error("pin rose outside pwm mode");
    a_rise_gap: assert property ($rose(pin) |=> (!$rose(pin)) [*3])
        else $error("period shorter than four clocks");
    a_zero_duty: assert property ($rose(pin) |-> $past(duty_w) != 10'h000)
        else $error("pin rose with zero duty");
endmodule

bind cpw_pwm_unit cpw_assertions i_chk
(
    .i_sys_clk           (i_sys_clk),
    .i_reset_n           (i_reset_n),
    .i_addr              (i_addr),
    .i_wdata             (i_wdata),
    .i_wr                (i_wr),
    .i_rd                (i_rd),
    .o_rdata             (o_rdata),
    .i_port_direction    (i_port_direction),
    .o_pwm_output_pin    (o_pwm_output_pin),
    .o_pwm_output_pin_oe (o_pwm_output_pin_oe)
);
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for the PWM unit
// Assumes: 100 ns clock, sync active-low reset
// Notes:   Pin widths judged at falling edges
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ----------
    // Hookup
    // ----------
    logic       clk;
    logic       rst_n;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr_s;
    logic       rd_s;
    logic [7:0] rdata;
    logic       dir;
    logic       pin;
    logic       oe;
    int         n_mismatch; // Mismatches
    int         tests_run;  // Comparisons
    int         cyc;        // Cycles run

    cpw_pwm_unit i_cpw_pwm_unit
    (
        .i_sys_clk           (clk),
        .i_reset_n           (rst_n),
        .i_addr              (addr),
        .i_wdata             (wdata),
        .i_wr                (wr_s),
        .i_rd                (rd_s),
        .o_rdata             (rdata),
        .i_port_direction    (dir),
        .o_pwm_output_pin    (pin),
        .o_pwm_output_pin_oe (oe)
    );

    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    // Hang guard; runs need under two thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    // ----------
    // Helpers
    // ----------
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s  <= 1'h1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_s  <= 1'h0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        rd_s <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'h0;
        @(negedge clk);
        v = rdata;
    endtask

    // Clocks until the pin shows v, counting the first
    task automatic wait_lvl(input logic v, output int n);
        n = 1;
        @(negedge clk);
        while (pin !== v && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic meas(output int hi, output int per);
        int n;
        wait_lvl(1'h0, n);
        wait_lvl(1'h1, n);
        wait_lvl(1'h0, hi);
        wait_lvl(1'h1, per);
        per = per + hi;
    endtask

    // Highs seen over 40 clocks after 40 settling clocks
    task automatic highs(output int n);
        repeat (40) @(negedge clk);
        n = 0;
        repeat (40)
        begin
            @(negedge clk);
            n += (pin === 1'h1);
        end
    endtask

    // Period 3, duty 11, then run and pwm mode last
    task automatic cfg(input logic [1:0] ps);
        wr(3'h2, 8'h00);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h03);
        wr(3'h3, 8'h02);
        wr(3'h5, 8'h30);
        wr(3'h2, {5'h00, 1'h1, ps});
        wr(3'h5, 8'h3C);
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_regs;
        logic [7:0] v;
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a), v);
            chk(v, (a == 1) ? 8'hFF : 8'h00);
        end
        wr(3'h2, 8'hFF);
        rd(3'h2, v);
        chk(v, 8'h7F);
        wr(3'h5, 8'hFF);
        rd(3'h5, v);
        chk(v, 8'h3F);
        wr(3'h5, 8'h00);
        wr(3'h2, 8'h00);
        wr(3'h6, 8'h5A);
        rd(3'h6, v);
        chk(v, 8'h00);
        wr(3'h0, 8'h02);
        repeat (2) rd(3'h0, v);
        chk(v, 8'h02);
        @(posedge clk);
        dir <= 1'h1;
        repeat (2) @(negedge clk);
        chk(oe, 1'h0);
        @(posedge clk);
        dir <= 1'h0;
        repeat (2) @(negedge clk);
        chk(oe, 1'h1);
    endtask

    task automatic t_pwm(input logic [1:0] ps);
        int hi;
        int per;
        int dv;
        dv = (ps == 2'h0) ? 1 : (ps == 2'h1) ? 4 : 16;
        cfg(ps);
        meas(hi, per);
        chk(per, 16 * dv);
        chk(hi, 11 * dv);
    endtask

    // Duty rewritten mid-pulse; current pulse keeps old value
    task automatic t_shadow;
        int n;
        int hi;
        int per;
        time t0;
        logic [7:0] v;
        cfg(2'h0);
        wait_lvl(1'h0, n);
        wait_lvl(1'h1, n);
        t0 = $time;
        wr(3'h3, 8'h01);
        wr(3'h5, 8'h0C);
        wait_lvl(1'h0, n);
        hi = int'(($time - t0) / 100);
        chk(hi, 11);
        meas(hi, per);
        chk(hi, 4);
        chk(per, 16);
        rd(3'h4, v);
        chk(v, 8'h01);
        wr(3'h4, 8'hAA);
        rd(3'h4, v);
        chk(v, 8'h01);
        repeat (6)
        begin
            rd(3'h0, v);
            chk(v <= 8'h03, 1'h1);
        end
    endtask

    task automatic t_levels;
        int n;
        // Low mode bits set too; PWM must still be selected
        wr(3'h5, 8'h0F);
        wr(3'h3, 8'hFF);
        highs(n);
        chk(n, 40);
        wr(3'h3, 8'h00);
        wr(3'h5, 8'h0C);
        highs(n);
        chk(n, 0);
        wr(3'h3, 8'h02);
        wr(3'h5, 8'h38);
        highs(n);
        chk(n, 0);
        wr(3'h5, 8'h3C);
        wr(3'h5, 8'h00);
        highs(n);
        chk(n, 0);
    endtask

    initial
    begin
        rst_n = 1'h0;
        addr = 3'h0;
        wdata = 8'h00;
        wr_s = 1'h0;
        rd_s = 1'h0;
        dir = 1'h1;
        n_mismatch = 0;
        tests_run = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        t_regs();
        for (int p = 0; p < 4; p++)
            t_pwm(2'(p));
        t_shadow();
        t_levels();
        finish_test();
    end
endmodule
`default_nettype wire
